// *** inc/motor_remote_io_mapper_regs.svh ***
// register offsets, function codes and reset values of the remote io mapper
// assumes a 32-bit axi4-lite slave with byte addresses
`ifndef MOTOR_REMOTE_IO_MAPPER_REGS_SVH
`define MOTOR_REMOTE_IO_MAPPER_REGS_SVH

// ==========
// offsets
`define OFS_IN_MAP0 8'h00
`define OFS_OUT_MAP0 8'h10
`define OFS_STATUS 8'h20
`define OFS_FLAGS 8'h24
`define OFS_CTRL 8'h28
`define CTRL_UNLOCK_DIRECT_BIT 0
`define CODE_MASK 8'h3f
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ==========
// input function codes
`define IC_UNUSED 6'h00
`define IC_RUN_POS 6'h01
`define IC_RUN_NEG 6'h02
`define IC_HOME 6'h03
`define IC_START 6'h04
`define IC_SEQ 6'h05
`define IC_INCH_POS 6'h06
`define IC_INCH_NEG 6'h07
`define IC_DPOS0 6'h08
`define IC_BRAKE 6'h0e
`define IC_CUR_OFF 6'h0f
`define IC_STOP 6'h10
`define IC_FCLR 6'h11
`define IC_PRESET 6'h12
`define IC_UNLOCK 6'h13
`define IC_FLAG0 6'h14
`define IC_OPSEL0 6'h24

// ==========
// output function codes; 01..10 echo input codes 01..10
`define OC_UNUSED 6'h00
`define OC_ECHO0 6'h01
`define OC_FLAG0 6'h11
`define OC_OPSEL0 6'h21
`define OC_SENSOR0 6'h27
`define OC_FAULT 6'h2b
`define OC_CAUTION 6'h2c
`define OC_READY 6'h2d
`define OC_MOVE 6'h2e
`define OC_HOMEP 6'h2f
`define OC_STEP 6'h30
`define OC_ZONE1 6'h31
`define OC_BUSY 6'h34

// ==========
// reset assignment, four 8-bit slots per word
`define IN_MAP_RST0 32'h04262524
`define IN_MAP_RST1 32'h0f001003
`define IN_MAP_RST2 32'h050a0908
`define IN_MAP_RST3 32'h02010706
`define OUT_MAP_RST0 32'h04232221
`define OUT_MAP_RST1 32'h2b2c2d2f
`define OUT_MAP_RST2 32'h33323134
`define OUT_MAP_RST3 32'h00002e30
`define CTRL_RST 32'h00000000

// ==========
// shaft pulse angle and motor step angle, millidegrees
`define SHAFT_PULSE_MDEG 7200
`define MOTOR_STEP_MDEG 720

`endif

// *** inc/motor_remote_io_pkg.sv ***
// types shared by the remote io mapper
// assumes nothing beyond the mapper itself
`default_nettype none

package motor_remote_io_pkg;

	// ==========
	// commands to the motion core
	typedef struct packed {
		logic run_pos;
		logic run_neg;
		logic stop;
		logic current_off;
		logic home_go;
		logic start_go;
		logic seq_go;
		logic inch_pos_go;
		logic inch_neg_go;
		logic [5:0] dpos_go;
		logic fault_clear;
		logic preset_go;
		logic panel_unlock;
		logic [5:0] op_select;
		logic [15:0] flags;
	} motion_cmd_t;

	// ==========
	// state reported by the motion core
	typedef struct packed {
		logic fault;
		logic caution;
		logic ready;
		logic moving;
		logic at_home;
		logic busy;
		logic [2:0] zone;
		logic step;
		logic step_dir;
	} motion_status_t;

	// ==========
	// asynchronous pins
	typedef struct packed {
		logic pos_limit;
		logic neg_limit;
		logic home_sensor;
		logic slit_sensor;
		logic panel_unlock;
	} sensor_pins_t;

endpackage

`default_nettype wire

// *** rtl/motor_remote_io_mapper.sv ***
// remote io mapper: network bits to motion functions and back, axi4-lite setup
// assumes net inputs and motion status share clk; sensor pins are asynchronous
//
// How it works
// - reset input map: select, start, home, stop, free, current-off, direct, seq, jogs, runs
// - reset output map: select echoes, start echo, home, ready, caution, fault, busy, zones
// - run inputs give level run commands; release means decelerating stop in the core
// - homing, start, sequence, inch and direct inputs start on their rising edge
// - current-off input at 1 de-energizes the windings, 0 keeps excitation
// - fault-clear input at 1 clears the present fault
// - six select bits form the operation data number
// - panel unlock is 1 when not assigned to any network bit and direct unlock is off
// - with direct and network unlock assigned, unlock needs both at 1
// - sixteen flags follow their input bits and have matching output functions
// - echo outputs show the present state of their input functions
// - limit, home sensor and slit echoes follow the synchronized sensor pins
// - fault and caution outputs follow the core's fault and caution state
// - ready, motion and home outputs follow the core's state
// - shaft pulse output high once per 7.2 degrees of shaft rotation
// - three zone outputs follow the core's zone indications
// - busy output follows internal processing state
`include "motor_remote_io_mapper_regs.svh"
`default_nettype none

module motor_remote_io_mapper #(
	parameter int NET_W = 16,
	parameter int ADDR_W = 8,
	parameter int STEPS_PER_PULSE = `SHAFT_PULSE_MDEG / `MOTOR_STEP_MDEG
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [NET_W-1:0] net_input_bits,
	output logic [NET_W-1:0] net_output_bits,
	input wire motor_remote_io_pkg::motion_status_t core_status,
	output motor_remote_io_pkg::motion_cmd_t core_cmd,
	input wire motor_remote_io_pkg::sensor_pins_t sensor_pins,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ==========
	// helpers
	function automatic logic [5:0] code_of(input logic [3:0][31:0] m, input logic [3:0] i);
		return m[i[3:2]][{i[1:0], 3'b000} +: 6];
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= `OFS_CTRL);
	endfunction

	// ==========
	// state
	logic [3:0][31:0] in_map_r;
	logic [3:0][31:0] out_map_r;
	logic [31:0] ctrl_r;
	logic [63:0] in_func;
	logic [63:0] in_prev_r;
	logic [63:0] out_func;
	logic [15:0] flags_r;
	motor_remote_io_pkg::sensor_pins_t sync1_r;
	motor_remote_io_pkg::sensor_pins_t sync2_r;
	logic [7:0] step_cnt_r;
	logic unlock_net_assigned;
	logic unlock_nxt;

	// ==========
	// sensor pin synchronizer
	// pins move at any time; two flops keep metastability out of the decode
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= sensor_pins;
			sync2_r <= sync1_r;
		end
	end

	// ==========
	// input decode
	// several bits on one code simply or together
	always_comb
	begin
		in_func = '0;
		for (int i = 0; i < NET_W; i++)
		begin
			if (net_input_bits[i])
				in_func[code_of(in_map_r, 4'(i))] = 1'b1;
		end
		in_func[`IC_UNUSED] = 1'b0;
	end

	always_comb
	begin
		// unlock stays released while software maps it to no bit and the direct unlock bit is clear
		unlock_net_assigned = 1'b0;
		for (int i = 0; i < NET_W; i++)
		begin
			if (code_of(in_map_r, 4'(i)) == `IC_UNLOCK)
				unlock_net_assigned = 1'b1;
		end
		unlock_nxt = (unlock_net_assigned ? in_func[`IC_UNLOCK] : 1'b1)
			& (ctrl_r[`CTRL_UNLOCK_DIRECT_BIT] ? sync2_r.panel_unlock : 1'b1);
	end

	// ==========
	// commands to the motion core
	// fault clear is a level: a held input keeps clearing a returning fault
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			in_prev_r <= '0;
			core_cmd <= '0;
			flags_r <= '0;
		end
		else
		begin
			in_prev_r <= in_func;
			core_cmd.run_pos <= in_func[`IC_RUN_POS];
			core_cmd.run_neg <= in_func[`IC_RUN_NEG];
			core_cmd.stop <= in_func[`IC_STOP];
			core_cmd.current_off <= in_func[`IC_CUR_OFF];
			// level starts would retrigger after each completed move
			core_cmd.home_go <= in_func[`IC_HOME] & ~in_prev_r[`IC_HOME];
			core_cmd.start_go <= in_func[`IC_START] & ~in_prev_r[`IC_START];
			core_cmd.seq_go <= in_func[`IC_SEQ] & ~in_prev_r[`IC_SEQ];
			core_cmd.inch_pos_go <= in_func[`IC_INCH_POS] & ~in_prev_r[`IC_INCH_POS];
			core_cmd.inch_neg_go <= in_func[`IC_INCH_NEG] & ~in_prev_r[`IC_INCH_NEG];
			core_cmd.dpos_go <= in_func[`IC_DPOS0 +: 6] & ~in_prev_r[`IC_DPOS0 +: 6];
			core_cmd.fault_clear <= in_func[`IC_FCLR];
			core_cmd.preset_go <= in_func[`IC_PRESET] & ~in_prev_r[`IC_PRESET];
			core_cmd.panel_unlock <= unlock_nxt;
			core_cmd.op_select <= in_func[`IC_OPSEL0 +: 6];
			core_cmd.flags <= in_func[`IC_FLAG0 +: 16];
			flags_r <= in_func[`IC_FLAG0 +: 16];
			// the brake code is decoded but drives no core command, only its echo output
		end
	end

	// ==========
	// shaft pulse
	// position within one pulse angle; high at the origin step
	// counting down on reverse steps keeps the pulse tied to shaft angle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			step_cnt_r <= '0;
		else if (core_status.step)
		begin
			if (core_status.step_dir)
				step_cnt_r <= (step_cnt_r == 8'(STEPS_PER_PULSE - 1)) ? '0 : step_cnt_r + 8'h01;
			else
				step_cnt_r <= (step_cnt_r == '0) ? 8'(STEPS_PER_PULSE - 1) : step_cnt_r - 8'h01;
		end
	end

	// ==========
	// output functions
	// codes above the busy code select nothing and read 0
	always_comb
	begin
		out_func = '0;
		out_func[`OC_ECHO0 +: 16] = in_func[`IC_RUN_POS +: 16];
		out_func[`OC_FLAG0 +: 16] = flags_r;
		out_func[`OC_OPSEL0 +: 6] = in_func[`IC_OPSEL0 +: 6];
		out_func[`OC_SENSOR0 +: 4] = {sync2_r.slit_sensor, sync2_r.home_sensor,
			sync2_r.neg_limit, sync2_r.pos_limit};
		out_func[`OC_FAULT] = core_status.fault;
		out_func[`OC_CAUTION] = core_status.caution;
		out_func[`OC_READY] = core_status.ready;
		out_func[`OC_MOVE] = core_status.moving;
		out_func[`OC_HOMEP] = core_status.at_home;
		out_func[`OC_STEP] = (step_cnt_r == '0);
		out_func[`OC_ZONE1 +: 3] = core_status.zone;
		out_func[`OC_BUSY] = core_status.busy;
		out_func[`OC_UNUSED] = 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			net_output_bits <= '0;
		else
		begin
			for (int i = 0; i < NET_W; i++)
				net_output_bits[i] <= out_func[code_of(out_map_r, 4'(i))];
		end
	end

	// ==========
	// axi4-lite write channel
	// response stands until bready, so a stalled master loses nothing
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic aw_take;
	logic w_take;
	logic commit;
	logic aw_hold_nxt;
	logic w_hold_nxt;
	logic bvalid_nxt;

	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign commit = aw_hold_r & w_hold_r & ~s_axi_bvalid;
	assign aw_hold_nxt = (aw_hold_r | aw_take) & ~commit;
	assign w_hold_nxt = (w_hold_r | w_take) & ~commit;
	assign bvalid_nxt = commit | (s_axi_bvalid & ~s_axi_bready);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end
		else
		begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			if (aw_take)
				aw_addr_r <= 8'(s_axi_awaddr);
			if (w_take)
			begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			// one write in flight; ready returns after the response is taken
			s_axi_awready <= ~aw_hold_nxt & ~bvalid_nxt;
			s_axi_wready <= ~w_hold_nxt & ~bvalid_nxt;
			s_axi_bvalid <= bvalid_nxt;
			if (commit)
				s_axi_bresp <= addr_ok(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
		end
	end

	// ==========
	// configuration registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			in_map_r <= {`IN_MAP_RST3, `IN_MAP_RST2, `IN_MAP_RST1, `IN_MAP_RST0};
			out_map_r <= {`OUT_MAP_RST3, `OUT_MAP_RST2, `OUT_MAP_RST1, `OUT_MAP_RST0};
			ctrl_r <= `CTRL_RST;
		end
		else if (commit)
		begin
			for (int b = 0; b < 4; b++)
			begin
				// misaligned writes are refused, so no slot lands in a neighbour word
				if (w_strb_r[b] && addr_ok(aw_addr_r))
				begin
					// upper slot bits are kept at zero so codes stay in range
					if (aw_addr_r[7:4] == `OFS_IN_MAP0 >> 4)
						in_map_r[aw_addr_r[3:2]][b*8 +: 8] <= w_data_r[b*8 +: 8] & `CODE_MASK;
					if (aw_addr_r[7:4] == `OFS_OUT_MAP0 >> 4)
						out_map_r[aw_addr_r[3:2]][b*8 +: 8] <= w_data_r[b*8 +: 8] & `CODE_MASK;
				end
			end
			if (aw_addr_r == `OFS_CTRL && w_strb_r[0])
				ctrl_r[`CTRL_UNLOCK_DIRECT_BIT] <= w_data_r[`CTRL_UNLOCK_DIRECT_BIT];
		end
	end

	// ==========
	// axi4-lite read channel
	// data is captured at the address handshake and held until rready
	logic ar_take;
	logic rvalid_nxt;
	logic [7:0] rd_addr;
	logic [31:0] rd_word;

	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);
	assign rd_addr = 8'(s_axi_araddr);

	always_comb
	begin
		rd_word = '0;
		if (rd_addr[7:4] == `OFS_IN_MAP0 >> 4)
			rd_word = in_map_r[rd_addr[3:2]];
		else if (rd_addr[7:4] == `OFS_OUT_MAP0 >> 4)
			rd_word = out_map_r[rd_addr[3:2]];
		else if (rd_addr == `OFS_STATUS)
			rd_word = {net_output_bits, net_input_bits};
		else if (rd_addr == `OFS_FLAGS)
			rd_word = {10'h000, core_cmd.op_select, flags_r};
		else if (rd_addr == `OFS_CTRL)
			rd_word = ctrl_r;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~rvalid_nxt;
			s_axi_rvalid <= rvalid_nxt;
			if (ar_take)
			begin
				s_axi_rdata <= addr_ok(rd_addr) ? rd_word : '0;
				s_axi_rresp <= addr_ok(rd_addr) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

endmodule

`default_nettype wire

// *** sim/motor_remote_io_mapper_sva.sv ***
// checker for the remote io mapper, sees top ports only
// assumes the bench keeps reset slots of in bits 3,4,7,14,15 and out bits 3-11 and 13
// in bit 2 may carry select or start, so the start echo allows either
`default_nettype none

module motor_remote_io_mapper_sva #(
	parameter int NET_W = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [NET_W-1:0] net_input_bits,
	input wire logic [NET_W-1:0] net_output_bits,
	input wire motor_remote_io_pkg::motion_status_t core_status,
	input wire motor_remote_io_pkg::motion_cmd_t core_cmd
);
	// ==========
	// sequences
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_start_rise;
		!net_input_bits[3] ##1 net_input_bits[3];
	endsequence
	sequence s_home_rise;
		!net_input_bits[4] ##1 net_input_bits[4];
	endsequence

	// ==========
	// properties
	property p_start_pulse;
		s_start_rise |=> core_cmd.start_go ##1 !core_cmd.start_go;
	endproperty
	property p_home_pulse;
		s_home_rise |=> core_cmd.home_go ##1 !core_cmd.home_go;
	endproperty
	property p_run_level;
		1 |=> core_cmd.run_pos == $past(net_input_bits[14])
			&& core_cmd.run_neg == $past(net_input_bits[15]);
	endproperty
	property p_current_off;
		1 |=> core_cmd.current_off == $past(net_input_bits[7]);
	endproperty
	property p_start_echo;
		1 |=> (net_output_bits[3] || !$past(net_input_bits[3]))
			&& (!net_output_bits[3] || $past(net_input_bits[3:2]) != 2'b00);
	endproperty
	property p_fault_caution;
		1 |=> net_output_bits[7] == $past(core_status.fault)
			&& net_output_bits[6] == $past(core_status.caution);
	endproperty
	property p_ready_home_move;
		1 |=> net_output_bits[5] == $past(core_status.ready)
			&& net_output_bits[4] == $past(core_status.at_home)
			&& net_output_bits[13] == $past(core_status.moving);
	endproperty
	property p_zones;
		1 |=> net_output_bits[11:9] == $past(core_status.zone);
	endproperty
	property p_busy;
		$changed(core_status.busy) |=> net_output_bits[8] == $past(core_status.busy);
	endproperty

	a_start_pulse: assert property (p_start_pulse) else $error("start pulse wrong");
	a_home_pulse: assert property (p_home_pulse) else $error("home pulse wrong");
	a_run_level: assert property (p_run_level) else $error("run level wrong");
	a_current_off: assert property (p_current_off) else $error("current off wrong");
	a_start_echo: assert property (p_start_echo) else $error("start echo wrong");
	a_fault_caution: assert property (p_fault_caution) else $error("fault out wrong");
	a_ready_home_move: assert property (p_ready_home_move) else $error("ready out wrong");
	a_zones: assert property (p_zones) else $error("zone out wrong");
	a_busy: assert property (p_busy) else $error("busy out wrong");
endmodule

bind motor_remote_io_mapper motor_remote_io_mapper_sva #(.NET_W(NET_W)) i_sva (
	.clk(clk),
	.reset_n(reset_n),
	.net_input_bits(net_input_bits),
	.net_output_bits(net_output_bits),
	.core_status(core_status),
	.core_cmd(core_cmd)
);

`default_nettype wire

// *** sim/motor_remote_io_mapper_tb.sv ***
// self-checking bench for the remote io mapper
// assumes net_converter_model and the bound checker are compiled first
`default_nettype none

module motor_remote_io_mapper_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========
	// signals
	logic clk, reset_n;
	logic [15:0] host_bits, net_input_bits, net_output_bits;
	motor_remote_io_pkg::motion_status_t core_status;
	motor_remote_io_pkg::motion_cmd_t core_cmd;
	motor_remote_io_pkg::sensor_pins_t sensor_pins;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int failures, total_checks;
	localparam logic [31:0] rst_map [8] = '{32'h04262524, 32'h0f001003, 32'h050a0908,
		32'h02010706, 32'h04232221, 32'h2b2c2d2f, 32'h33323134, 32'h00002e30};

	motor_remote_io_mapper i_motor_remote_io_mapper (
		.clk, .reset_n, .net_input_bits, .net_output_bits, .core_status, .core_cmd,
		.sensor_pins, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	net_converter_model i_net_converter_model (.clk, .reset_n, .host_bits, .net_input_bits);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========
	// tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		n = 0;
		do
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
			if (n > 50)
				failures++;
			if (n > 50)
				summarize();
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check("bresp", s_axi_bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		n = 0;
		do
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
			if (n > 50)
				failures++;
			if (n > 50)
				summarize();
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check("rdata", s_axi_rdata, ed);
		check("rresp", s_axi_rresp, er);
	endtask

	// host word reaches the core three edges later, when start pulses show
	task automatic drive(input logic [15:0] v);
		@(posedge clk);
		host_bits <= v;
		repeat (3) @(posedge clk);
	endtask

	// ==========
	// sequence of tests
	initial
	begin
		failures = 0;
		total_checks = 0;
		reset_n = 1'b0;
		host_bits = 16'h0000;
		core_status = '0;
		sensor_pins = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(8'(i * 4), rst_map[i], 2'h0);
		rd(8'h2c, 32'h0, 2'h2);
		wr(8'h2c, 32'h1, 2'h2);
		wr(8'h20, 32'hffffffff, 2'h0);
		// shaft pulse out is high at step count zero
		rd(8'h20, 32'h10000000, 2'h0);
		$display("test bus done");
		drive(16'h7fbf);
		check("go", core_cmd[35:25], 11'h7c7);
		repeat (4) @(posedge clk);
		check("levels", {core_cmd[39:36], core_cmd.op_select}, 10'h2c7);
		check("echo", net_output_bits[3:0], 4'hf);
		drive(16'h8000);
		check("runs", {core_cmd.run_pos, core_cmd.run_neg}, 2'h1);
		drive(16'h0000);
		$display("test inputs done");
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			core_status <= i ? 11'h000 : 11'h7fc;
			repeat (4) @(posedge clk);
			check("status out", net_output_bits[15:4], i ? 12'h100 : 12'h3ff);
		end
		for (int i = 1; i <= 10; i++)
		begin
			@(posedge clk);
			core_status <= 11'h003;
			@(posedge clk);
			core_status <= 11'h001;
			repeat (4) @(posedge clk);
			check("shaft pulse", net_output_bits[12], i == 10);
		end
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			core_status <= i ? 11'h003 : 11'h002;
			@(posedge clk);
			core_status <= 11'h000;
			repeat (4) @(posedge clk);
			check("shaft back", net_output_bits[12], i == 1);
		end
		$display("test outputs done");
		// brake code is never assigned: this motor family has none
		wr(8'h00, 32'h04041400, 2'h0);
		wr(8'h10, 32'h043f0011, 2'h0);
		wr(8'h1c, 32'h27002e30, 2'h0);
		wr(8'h04, 32'h0f111203, 2'h0);
		sensor_pins <= 5'h10;
		drive(16'h0067);
		check("dup start", {core_cmd[35:25], core_cmd.preset_go}, 12'h401);
		repeat (4) @(posedge clk);
		check("unused in", core_cmd.op_select, 6'h00);
		check("flags", core_cmd.flags, 16'h0001);
		rd(8'h24, 32'h00000001, 2'h0);
		check("clear", core_cmd.fault_clear, 1'b1);
		check("unlock free", core_cmd.panel_unlock, 1'b1);
		check("remap out", {net_output_bits[15], net_output_bits[2:0]}, 4'h9);
		wr(8'h04, 32'h0f131003, 2'h0);
		wr(8'h28, 32'h1, 2'h0);
		drive(16'h0040);
		repeat (4) @(posedge clk);
		check("unlock pin low", core_cmd.panel_unlock, 1'b0);
		sensor_pins <= 5'h11;
		repeat (5) @(posedge clk);
		check("unlock both", core_cmd.panel_unlock, 1'b1);
		drive(16'h0000);
		check("unlock net low", core_cmd.panel_unlock, 1'b0);
		$display("test remap done");
		summarize();
	end
endmodule

`default_nettype wire

// *** sim/net_converter_model.sv ***
// network converter model: relays the host's input word to the device
// assumes the host changes its word just after a rising edge
`default_nettype none

module net_converter_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [15:0] host_bits,
	output logic [15:0] net_input_bits
);
	// ==========
	// relay
	// one register stage, as a converter forwards once per scan
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			net_input_bits <= 16'h0000;
		else
			net_input_bits <= host_bits;
	end
endmodule

`default_nettype wire
